/* File: hdl/dbsm_defines.vh */
// Constants for the decoder error rate and sync monitor.
// Assumes an 8-bit register port with a 5-bit address, 20 MHz system clock.
`ifndef DBSM_DEFINES_VH
`define DBSM_DEFINES_VH

// Register port offsets
`define DBSM_ADDR_W 5
`define DBSM_OFS_ERR_RES_A 5'h03
`define DBSM_OFS_ERR_RES_B 5'h04
`define DBSM_OFS_SYNC_PER 5'h08
`define DBSM_OFS_SYNC_NORM 5'h09
`define DBSM_OFS_ERR_PER_A 5'h0A
`define DBSM_OFS_ERR_PER_B 5'h0B
`define DBSM_OFS_ERR_PER_C 5'h0C
`define DBSM_OFS_ERR_APPLY 5'h18

// Error rate monitor
`define DBSM_CODE_PER_UNIT 10'h3E8
`define DBSM_CODE_PRE_W 10
`define DBSM_PERIOD_W 24
`define DBSM_ERR_W 16
`define DBSM_ERR_RST 16'h0001
`define DBSM_ERR_SAT 16'h0000
`define DBSM_ERR_PRE_W 3
`define DBSM_ERR_PRE_LAST 3'h7
`define DBSM_DONE_EDGES 2'h2

// Sync monitor
`define DBSM_SYNC_W 8
`define DBSM_TCNT_W 16
`define DBSM_NCNT_W 12
`define DBSM_NORM_STEP_SH 3
`define DBSM_NORM_OFFSET 12'h004

// Port data
`define DBSM_BYTE_ZERO 8'h00

`endif

/* File: hdl/dbsm_monitor.v */
// Error rate and normalization rate monitors of a convolutional decoder.
// Assumes every pin input is asynchronous to clk_i; the decoder output clock
// is sampled and edge detected, so it must run well below half of clk_i.
`timescale 1ns/1ps
`include "dbsm_defines.vh"

module dbsm_monitor #(
	parameter RX_DELAY = 4,
	parameter [6:0] GEN_A = 7'h79,
	parameter [6:0] GEN_B = 7'h5B
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire decoder_output_clock_i,
	input wire decoded_bit_i,
	input wire [1:0] rx_code_i,
	input wire normalization_i,
	input wire trellis_mode_i,
	input wire [`DBSM_ADDR_W-1:0] proc_addr_i,
	input wire [7:0] proc_data_i,
	input wire proc_cs_n_i,
	input wire proc_wr_n_i,
	input wire proc_rd_n_i,
	output reg [7:0] proc_data_o,
	output reg proc_data_oe_n_o,
	output reg error_measure_done_o,
	output reg sync_good_o,
	output reg sync_lost_o
);

////////////////////////////////////////////////////////////////////////////////
// Allowed normalizations from the programmed limit
function [`DBSM_NCNT_W-1:0] dbsm_allowed;
	input [`DBSM_SYNC_W-1:0] neg_cnt;
	reg [`DBSM_NCNT_W-1:0] cnt;
	begin
		cnt = {4'h0, (~neg_cnt) + 8'h01};
		dbsm_allowed = ((cnt - 12'h001) << `DBSM_NORM_STEP_SH) + `DBSM_NORM_OFFSET;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, two flops each
localparam SYN_W = 3 + 2 + 1 + `DBSM_ADDR_W + 8 + 3;
wire [SYN_W-1:0] pins_raw;
reg [SYN_W-1:0] pins_s1_r;
reg [SYN_W-1:0] pins_s2_r;
assign pins_raw = {decoder_output_clock_i, decoded_bit_i, normalization_i, rx_code_i,
	trellis_mode_i, proc_addr_i, proc_data_i, proc_cs_n_i, proc_wr_n_i, proc_rd_n_i};

always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		pins_s1_r <= {SYN_W{1'b0}};
		pins_s2_r <= {SYN_W{1'b1}};
	end else begin
		pins_s1_r <= pins_raw;
		pins_s2_r <= pins_s1_r;
	end
end

wire dclk_s;
wire dbit_s;
wire norm_s;
wire [1:0] rx_s;
wire trellis_s;
wire [`DBSM_ADDR_W-1:0] addr_s;
wire [7:0] wdata_s;
wire cs_n_s;
wire wr_n_s;
wire rd_n_s;
assign {dclk_s, dbit_s, norm_s, rx_s, trellis_s, addr_s, wdata_s, cs_n_s, wr_n_s, rd_n_s} =
	pins_s2_r;

////////////////////////////////////////////////////////////////////////////////
// Decoder clock edge and write strobe
reg dclk_d_r;
reg wr_n_d_r;
wire bit_tick;
wire wr_stb;
always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		// Match the all-ones sync stage so reset gives no false edge
		dclk_d_r <= 1'b1;
		wr_n_d_r <= 1'b1;
	end else begin
		dclk_d_r <= dclk_s;
		wr_n_d_r <= wr_n_s;
	end
end
assign bit_tick = dclk_s & ~dclk_d_r;
// Write taken on release, data settled by then
assign wr_stb = wr_n_s & ~wr_n_d_r & ~cs_n_s;
wire sync_load;
assign sync_load = wr_stb & (addr_s == `DBSM_OFS_SYNC_PER);

////////////////////////////////////////////////////////////////////////////////
// Register file
reg [`DBSM_SYNC_W-1:0] sync_period_count_r;
reg [`DBSM_SYNC_W-1:0] sync_normalization_limit_r;
reg [`DBSM_PERIOD_W-1:0] error_period_stage_r;
reg [`DBSM_PERIOD_W-1:0] error_period_live_r;
reg apply_req_r;
always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		sync_period_count_r <= `DBSM_BYTE_ZERO;
		sync_normalization_limit_r <= `DBSM_BYTE_ZERO;
		error_period_stage_r <= {`DBSM_PERIOD_W{1'b0}};
		error_period_live_r <= {`DBSM_PERIOD_W{1'b0}};
		apply_req_r <= 1'b0;
	end else begin
		apply_req_r <= 1'b0;
		if (wr_stb) begin
			case (addr_s)
			`DBSM_OFS_SYNC_PER: sync_period_count_r <= wdata_s;
			`DBSM_OFS_SYNC_NORM: sync_normalization_limit_r <= wdata_s;
			`DBSM_OFS_ERR_PER_A: error_period_stage_r[7:0] <= wdata_s;
			`DBSM_OFS_ERR_PER_B: error_period_stage_r[15:8] <= wdata_s;
			`DBSM_OFS_ERR_PER_C: error_period_stage_r[23:16] <= wdata_s;
			`DBSM_OFS_ERR_APPLY: begin
				error_period_live_r <= error_period_stage_r;
				apply_req_r <= 1'b1;
			end
			default: ;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Re-encode and compare
reg [6:0] enc_sr_r;
reg [2*RX_DELAY-1:0] rx_dly_r;
reg [1:0] bit_err_r;
wire [1:0] miss;
wire [6:0] enc_win;
wire [1:0] reenc;
assign enc_win = {dbit_s, enc_sr_r[6:1]};
assign reenc = {^(enc_win & GEN_B), ^(enc_win & GEN_A)};
assign miss = reenc ^ rx_dly_r[2*RX_DELAY-1:2*RX_DELAY-2];

always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		enc_sr_r <= 7'h00;
		rx_dly_r <= {2*RX_DELAY{1'b0}};
		bit_err_r <= 2'h0;
	end else begin
		bit_err_r <= 2'h0;
		if (bit_tick) begin
			enc_sr_r <= enc_win;
			rx_dly_r <= {rx_dly_r[2*RX_DELAY-3:0], rx_s};
			bit_err_r <= {miss[1] & miss[0], miss[1] ^ miss[0]};
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Error rate measurement
reg ber_run_r;
reg ber_tick_r;
reg [`DBSM_CODE_PRE_W-1:0] code_pre_r;
reg [`DBSM_PERIOD_W-1:0] code_cnt_r;
reg [`DBSM_ERR_PRE_W-1:0] err_pre_r;
reg [`DBSM_ERR_W-1:0] err_acc_r;
reg [`DBSM_ERR_W-1:0] err_hold_r;
reg [1:0] done_cnt_r;
wire ber_en;
wire [3:0] err_sum;
wire err_carry;
wire unit_end;
wire period_end;
assign ber_en = ber_run_r & ~trellis_s;
assign err_sum = {1'b0, err_pre_r} + {2'h0, bit_err_r};
assign err_carry = err_sum[3] & (err_acc_r != `DBSM_ERR_SAT);
assign unit_end = (code_pre_r == `DBSM_CODE_PER_UNIT - 10'h002);
assign period_end = ber_tick_r & unit_end & (code_cnt_r == {`DBSM_PERIOD_W{1'b1}});

always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		ber_run_r <= 1'b0;
		ber_tick_r <= 1'b0;
		code_pre_r <= {`DBSM_CODE_PRE_W{1'b0}};
		code_cnt_r <= {`DBSM_PERIOD_W{1'b0}};
		err_pre_r <= {`DBSM_ERR_PRE_W{1'b0}};
		err_acc_r <= `DBSM_ERR_RST;
		err_hold_r <= `DBSM_ERR_RST;
		done_cnt_r <= 2'h0;
		error_measure_done_o <= 1'b0;
	end else begin
		// Stage delay lines the counter up with the compare result
		ber_tick_r <= bit_tick;
		if (apply_req_r) begin
			ber_run_r <= 1'b1;
			code_pre_r <= {`DBSM_CODE_PRE_W{1'b0}};
			code_cnt_r <= error_period_live_r;
			err_pre_r <= {`DBSM_ERR_PRE_W{1'b0}};
			err_acc_r <= `DBSM_ERR_RST;
		end else if (ber_en && ber_tick_r) begin
			// two code bits per decoded bit
			if (unit_end) begin
				code_pre_r <= {`DBSM_CODE_PRE_W{1'b0}};
				code_cnt_r <= code_cnt_r + 24'h000001;
			end else begin
				code_pre_r <= code_pre_r + 10'h002;
			end
			if (period_end) begin
				err_hold_r <= err_carry ? err_acc_r + 16'h0001 : err_acc_r;
				code_cnt_r <= error_period_live_r;
				err_pre_r <= {`DBSM_ERR_PRE_W{1'b0}};
				err_acc_r <= `DBSM_ERR_RST;
			end else if (err_acc_r != `DBSM_ERR_SAT) begin
				err_pre_r <= err_sum[2:0];
				// wrap lands on zero and sticks
				if (err_sum[3])
					err_acc_r <= err_acc_r + 16'h0001;
			end
		end
		if (period_end && ber_en) begin
			done_cnt_r <= `DBSM_DONE_EDGES;
			error_measure_done_o <= 1'b1;
		end else if (bit_tick && done_cnt_r != 2'h0) begin
			done_cnt_r <= done_cnt_r - 2'h1;
			error_measure_done_o <= (done_cnt_r != 2'h1);
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Normalization rate monitor
reg [`DBSM_TCNT_W-1:0] t_cnt_r;
reg [`DBSM_NCNT_W-1:0] n_cnt_r;
reg norm_d_r;
wire norm_evt;
wire t_end;
wire over_limit;
assign norm_evt = norm_s & ~norm_d_r;
assign t_end = bit_tick & (t_cnt_r == {`DBSM_TCNT_W{1'b1}});
assign over_limit = n_cnt_r > dbsm_allowed(sync_normalization_limit_r);

always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		t_cnt_r <= {`DBSM_TCNT_W{1'b0}};
		n_cnt_r <= {`DBSM_NCNT_W{1'b0}};
		norm_d_r <= 1'b1;
		sync_good_o <= 1'b0;
		sync_lost_o <= 1'b0;
	end else begin
		norm_d_r <= norm_s;
		sync_lost_o <= 1'b0;
		if (sync_load) begin
			// new period value restarts the test
			t_cnt_r <= {wdata_s, `DBSM_BYTE_ZERO};
			n_cnt_r <= {`DBSM_NCNT_W{1'b0}};
		end else if (t_end) begin
			sync_good_o <= ~over_limit;
			sync_lost_o <= over_limit;
			t_cnt_r <= {sync_period_count_r, 8'h00};
			n_cnt_r <= {`DBSM_NCNT_W{1'b0}};
		end else begin
			if (bit_tick)
				t_cnt_r <= t_cnt_r + 16'h0001;
			// Saturate so a long burst cannot wrap under the limit
			if (norm_evt && n_cnt_r != {`DBSM_NCNT_W{1'b1}})
				n_cnt_r <= n_cnt_r + 12'h001;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Read port, drives only while selected and reading
always @(posedge clk_i or negedge arst_n_i) begin
	if (!arst_n_i) begin
		proc_data_o <= `DBSM_BYTE_ZERO;
		proc_data_oe_n_o <= 1'b1;
	end else begin
		proc_data_oe_n_o <= cs_n_s | rd_n_s;
		case (addr_s)
		`DBSM_OFS_ERR_RES_A: proc_data_o <= err_hold_r[7:0];
		`DBSM_OFS_ERR_RES_B: proc_data_o <= err_hold_r[15:8];
		default: proc_data_o <= `DBSM_BYTE_ZERO;
		endcase
	end
end

endmodule // dbsm_monitor

/* File: tb/dbsm_chk_monitor.sv */
// Port checker for the decoder monitors.
// Assumes it is bound onto dbsm_monitor.
`timescale 1ns/1ps
module dbsm_chk (
	input wire clk_i,
	input wire arst_n_i,
	input wire decoder_output_clock_i,
	input wire trellis_mode_i,
	input wire proc_cs_n_i,
	input wire proc_rd_n_i,
	input wire proc_data_oe_n_o,
	input wire error_measure_done_o,
	input wire sync_good_o,
	input wire sync_lost_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Sync stages hide a pin edge for a few cycles
	sequence dec_still;
		$stable(decoder_output_clock_i) [*8];
	endsequence
	sequence rd_on;
		!proc_rd_n_i && !proc_cs_n_i;
	endsequence
	sequence done_up;
		$rose(error_measure_done_o);
	endsequence
	////////////////////////////////////////
	done_hold_a: assert property (done_up |-> error_measure_done_o [*8])
		else $error("done pulse short");
	done_end_a: assert property (done_up |-> ##[8:200] !error_measure_done_o)
		else $error("done pulse long");
	done_still_a: assert property (dec_still |-> !$rose(error_measure_done_o))
		else $error("done without decoder clock");
	trel_off_a: assert property (trellis_mode_i [*8] |-> !$rose(error_measure_done_o))
		else $error("done in trellis mode");
	lost_pulse_a: assert property (sync_lost_o |=> !sync_lost_o)
		else $error("sync lost not a pulse");
	lost_good_a: assert property (sync_lost_o |=> !sync_good_o)
		else $error("sync good with sync lost");
	oe_on_a: assert property (rd_on [*5] |-> !proc_data_oe_n_o)
		else $error("read not driven");
	oe_off_a: assert property (proc_rd_n_i [*5] |-> proc_data_oe_n_o)
		else $error("bus driven without read");
endmodule // dbsm_chk
bind dbsm_monitor dbsm_chk i_chk (
	.clk_i(clk_i), .arst_n_i(arst_n_i),
	.decoder_output_clock_i(decoder_output_clock_i), .trellis_mode_i(trellis_mode_i),
	.proc_cs_n_i(proc_cs_n_i), .proc_rd_n_i(proc_rd_n_i),
	.proc_data_oe_n_o(proc_data_oe_n_o), .error_measure_done_o(error_measure_done_o),
	.sync_good_o(sync_good_o), .sync_lost_o(sync_lost_o)
);

/* File: tb/dbsm_proc_model.sv */
// Processor side of the register port.
// Assumes strobes are taken on clk_i rising edges.
`timescale 1ns/1ps
module dbsm_proc_model (
	input wire clk_i,
	input wire [7:0] rdata_i,
	output logic [4:0] addr_o = 5'h00,
	output logic [7:0] data_o = 8'h00,
	output logic cs_n_o = 1'b1,
	output logic wr_n_o = 1'b1,
	output logic rd_n_o = 1'b1
);
	// Hold addr and data past the synced strobe
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		data_o = d;
		cs_n_o = 1'b0;
		wr_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
		wr_n_o = 1'b1;
		repeat (4) @(negedge clk_i);
		cs_n_o = 1'b1;
		data_o = ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		@(negedge clk_i);
		addr_o = a;
		cs_n_o = 1'b0;
		rd_n_o = 1'b0;
		repeat (6) @(posedge clk_i);
		q = rdata_i;
		@(negedge clk_i);
		rd_n_o = 1'b1;
		cs_n_o = 1'b1;
		repeat (5) @(negedge clk_i);
	endtask
endmodule // dbsm_proc_model

/* File: tb/tb_top.sv */
// Self-checking bench of the decoder monitors.
// Assumes the processor model owns the register port.
`timescale 1ns/1ps
`include "dbsm_defines.vh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_top;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic dclk = 1'b0;
	logic dbit = 1'b0;
	logic [1:0] rx = 2'h0;
	logic norm = 1'b0;
	logic trel = 1'b0;
	logic done_q = 1'b0;
	logic [7:0] q;
	logic [15:0] got;
	wire [4:0] addr;
	wire [7:0] wdata, rdata;
	wire cs_n, wr_n, rd_n, oe_n, done, good, lost;
	int fails = 0;
	int cmp_count = 0;
	int done_cnt = 0;
	int lost_cnt = 0;
	int k[3];
	always #25 clk_i = ~clk_i;
	dbsm_monitor i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .decoder_output_clock_i(dclk),
		.decoded_bit_i(dbit), .rx_code_i(rx), .normalization_i(norm), .trellis_mode_i(trel),
		.proc_addr_i(addr), .proc_data_i(wdata), .proc_cs_n_i(cs_n), .proc_wr_n_i(wr_n),
		.proc_rd_n_i(rd_n), .proc_data_o(rdata), .proc_data_oe_n_o(oe_n),
		.error_measure_done_o(done), .sync_good_o(good), .sync_lost_o(lost));
	dbsm_proc_model i_proc (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .data_o(wdata),
		.cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n));
	always @(posedge clk_i) begin
		done_q <= done;
		if (done === 1'b1 && done_q === 1'b0)
			done_cnt <= done_cnt + 1;
		if (lost === 1'b1)
			lost_cnt <= lost_cnt + 1;
	end
	////////////////////////////////////////
	function automatic logic [15:0] exp_res(int n);
		return 16'h0001 + 16'(2 * n / 8);
	endfunction
	// Errors sit mid-period, clear of start and end skew
	function automatic bit err_at(int i);
		return i < 1500 && i % 500 >= 100 && i % 500 < 100 + k[i / 500];
	endfunction
	task automatic drive(int n, bit inj);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_i);
			dclk = 1'b0;
			dbit = trel ? 1'($urandom) : 1'b0;
			rx = (inj && err_at(i)) ? 2'h3 : 2'h0;
			norm = trel ? 1'b0 : 1'($urandom);
			repeat (4) @(negedge clk_i);
			dclk = 1'b1;
			repeat (3) @(negedge clk_i);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_done(int n);
		for (int t = 0; t < 8000 && done_cnt < n; t++)
			@(posedge clk_i);
		if (done_cnt < n) begin
			fails++;
			end_of_test();
		end
	endtask
	initial begin
		void'($urandom(32'hE73A779D));
		k[0] = 3;
		k[1] = 4;
		k[2] = 1 + $urandom % 60;
		repeat (16) @(negedge clk_i);
		arst_n_i = 1'b1;
		repeat (3) @(negedge clk_i);
		i_proc.wr(`DBSM_OFS_SYNC_PER, 8'hFE);
		i_proc.wr(`DBSM_OFS_SYNC_NORM, 8'hF9);
		i_proc.rd(`DBSM_OFS_SYNC_PER, q);
		`CHK("sync_period_count", 8'h00, q)
		i_proc.rd(5'h1F, q);
		`CHK("unmapped", 8'h00, q)
		// one unit of 1000 code bits
		i_proc.wr(`DBSM_OFS_ERR_PER_A, 8'hFF);
		i_proc.wr(`DBSM_OFS_ERR_PER_B, 8'hFF);
		i_proc.wr(`DBSM_OFS_ERR_PER_C, 8'hFF);
		drive(600, 1'b0);
		`CHK("done_before_apply", 0, done_cnt)
		i_proc.wr(`DBSM_OFS_ERR_APPLY, 8'($urandom));
		fork
			drive(1510, 1'b1);
			for (int p = 0; p < 3; p++) begin
				wait_done(p + 1);
				i_proc.rd(`DBSM_OFS_ERR_RES_A, got[7:0]);
				i_proc.rd(`DBSM_OFS_ERR_RES_B, got[15:8]);
				`CHK("error_result", exp_res(k[p]), got)
			end
		join
		trel = 1'b1;
		drive(600, 1'b0);
		`CHK("done_in_trellis", 3, done_cnt)
		`CHK("sync_lost_count", 4, lost_cnt)
		`CHK("sync_good", 1'b1, good)
		end_of_test();
	end
endmodule // tb_top
